// *** logic/cfi_core.sv ***
// Our own choices: strobed register access and the placing of the registers.
`default_nettype none
module cfi_core
  import cfi_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic        irq_req_in,
  input  wire logic        nonmaskable_pin_request_in,
  output logic [31:0]      reg_rdata_out,
  output logic [7:0]       flag_register_out,
  output logic [15:0]      program_counter_out,
  output logic             busy_out,
  output logic             halted_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  cfi_state_t   state_r, state_nxt;
  logic [3:0]   cnt_r, cnt_nxt;
  logic [7:0]   flags_r, flags_nxt;
  logic [15:0]  pc_r, pc_nxt, sp_r, sp_nxt, x_r, x_nxt, y_r, y_nxt;
  logic [7:0]   a_r, a_nxt, b_r, b_nxt;
  logic         irq_pend_r, irq_pend_nxt, pin_pend_r, pin_pend_nxt;
  logic         pin_sel_r, pin_sel_nxt, halted_r, halted_nxt, busy_r;
  logic [31:0]  rdata_r;
  cfi_stk_req_t stk;
  logic [7:0]   stk_rdata;

  function automatic logic cond_true(input cfi_cond_t c, input logic [7:0] f);
    logic n, z, v, cy;
    n  = f[FB_N];
    z  = f[FB_Z];
    v  = f[FB_V];
    cy = f[FB_C];
    case (c)
      BR_MI:     cond_true = n;
      BR_PL:     cond_true = ~n;
      BR_EQ:     cond_true = z;
      BR_NE:     cond_true = ~z;
      BR_VS:     cond_true = v;
      BR_VC:     cond_true = ~v;
      BR_CS:     cond_true = cy;
      BR_CC:     cond_true = ~cy;
      BR_LT:     cond_true = n ^ v;
      BR_GE:     cond_true = ~(n ^ v);
      BR_LE:     cond_true = z | (n ^ v);
      BR_GT:     cond_true = ~(z | (n ^ v));
      BR_HI:     cond_true = ~(cy | z);
      BR_LS:     cond_true = cy | z;
      BR_ALWAYS: cond_true = 1'b1;
      default:   cond_true = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] stk_byte(input logic [3:0] i, input logic [15:0] pc, input logic [15:0] y,
                                          input logic [15:0] x, input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] f);
    case (i)
      4'h0:    stk_byte = pc[7:0];
      4'h1:    stk_byte = pc[15:8];
      4'h2:    stk_byte = y[7:0];
      4'h3:    stk_byte = y[15:8];
      4'h4:    stk_byte = x[7:0];
      4'h5:    stk_byte = x[15:8];
      4'h6:    stk_byte = a;
      4'h7:    stk_byte = b;
      default: stk_byte = f;
    endcase
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  cfi_instr_t ins;
  assign ins = cfi_instr_t'(reg_wdata_in[19:0]);

  wire idle     = (state_r == ST_IDLE);
  wire want_pin = pin_pend_r & ~flags_r[FB_X];
  wire want_irq = irq_pend_r & ~flags_r[FB_I];
  wire wr_hit   = reg_wr_in & idle & ~halted_r;
  wire ins_go   = wr_hit & (reg_addr_in == REG_INSTR);
  wire take     = idle & ~ins_go & (want_pin | want_irq);

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  wire [7:0]  opnd  = (ins.op == OP_ADD_B_INTO_A) ? b_r : ins.imm;
  wire        cin   = (ins.op == OP_ADC) & flags_r[FB_C];
  wire [8:0]  sum9  = {1'b0, a_r} + {1'b0, opnd} + {8'h00, cin};
  wire [4:0]  half5 = {1'b0, a_r[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  wire [8:0]  dif9  = {1'b0, a_r} - {1'b0, ins.imm};
  wire        add_v = (a_r[7] == opnd[7]) & (sum9[7] != a_r[7]);
  wire        sub_v = (a_r[7] != ins.imm[7]) & (dif9[7] != a_r[7]);
  wire        lo_fx = (a_r[3:0] > 4'h9) | flags_r[FB_H];
  wire        hi_fx = (a_r[7:4] > 4'h9) | flags_r[FB_C] | ((a_r[7:4] > 4'h8) & (a_r[3:0] > 4'h9));
  wire [7:0]  daa_val = a_r + {(hi_fx ? 4'h6 : 4'h0), (lo_fx ? 4'h6 : 4'h0)};
  wire [15:0] prod  = a_r * b_r;
  wire [15:0] br_to = pc_r + 16'h0001 + {{8{ins.imm[7]}}, ins.imm};
  wire [15:0] sp_up = sp_r + 16'h0001;
  wire [15:0] sp_dn = sp_r - 16'h0001;
  wire [3:0]  pidx  = PULL_LAST - cnt_r;

  // stack port: reads run one cycle ahead of the capture
  assign stk.we   = (state_r == ST_PUSH);
  assign stk.addr = (state_r == ST_PUSH) ? sp_r[STK_AW-1:0] : sp_up[STK_AW-1:0];
  assign stk.data = stk_byte(cnt_r, pc_r, y_r, x_r, a_r, b_r, flags_r);

  cfi_stack_mem u_stack (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .req_in      (stk),
    .rdata_out   (stk_rdata)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    flags_nxt  = flags_r;
    pc_nxt     = pc_r;
    sp_nxt     = sp_r;
    x_nxt      = x_r;
    y_nxt      = y_r;
    a_nxt      = a_r;
    b_nxt      = b_r;
    halted_nxt = halted_r;
    pin_sel_nxt = pin_sel_r;
    // event wins over the clear in the same cycle
    irq_pend_nxt = irq_pend_r | irq_req_in;
    pin_pend_nxt = pin_pend_r | nonmaskable_pin_request_in;
    if (ins_go) begin
      pc_nxt = pc_r + 16'h0001;
      case (ins.op)
        OP_ADD_B_INTO_A, OP_ADD, OP_ADC: begin
          a_nxt = sum9[7:0];
          flags_nxt[FB_H] = half5[4];
          flags_nxt[FB_N] = sum9[7];
          flags_nxt[FB_Z] = (sum9[7:0] == 8'h00);
          flags_nxt[FB_V] = add_v;
          flags_nxt[FB_C] = sum9[8];
        end
        OP_SUB, OP_CMP: begin
          if (ins.op == OP_SUB) begin
            a_nxt = dif9[7:0];
          end
          flags_nxt[FB_N] = dif9[7];
          flags_nxt[FB_Z] = (dif9[7:0] == 8'h00);
          flags_nxt[FB_V] = sub_v;
          flags_nxt[FB_C] = dif9[8];
        end
        OP_DECIMAL_ADJUST_ACC: begin
          a_nxt = daa_val;
          flags_nxt[FB_N] = daa_val[7];
          flags_nxt[FB_Z] = (daa_val == 8'h00);
          flags_nxt[FB_C] = flags_r[FB_C] | hi_fx;
        end
        OP_LOAD_ACC_ONE, OP_STORE_ACC_ONE: begin
          // moved value sets N Z, V cleared
          if (ins.op == OP_LOAD_ACC_ONE) begin
            a_nxt = ins.imm;
          end
          flags_nxt[FB_N] = (ins.op == OP_LOAD_ACC_ONE) ? ins.imm[7] : a_r[7];
          flags_nxt[FB_Z] = ((ins.op == OP_LOAD_ACC_ONE) ? ins.imm : a_r) == 8'h00;
          flags_nxt[FB_V] = 1'b0;
        end
        OP_LOAD_ACC_TWO: begin
          b_nxt = ins.imm;
          flags_nxt[FB_N] = ins.imm[7];
          flags_nxt[FB_Z] = (ins.imm == 8'h00);
          flags_nxt[FB_V] = 1'b0;
        end
        OP_INCREMENT_INDEX_ONE, OP_DECREMENT_INDEX_ONE: begin
          x_nxt = (ins.op == OP_INCREMENT_INDEX_ONE) ? x_r + 16'h0001 : x_r - 16'h0001;
          flags_nxt[FB_Z] = (x_nxt == 16'h0000);
        end
        OP_INCREMENT_INDEX_TWO, OP_DECREMENT_INDEX_TWO: begin
          y_nxt = (ins.op == OP_INCREMENT_INDEX_TWO) ? y_r + 16'h0001 : y_r - 16'h0001;
          flags_nxt[FB_Z] = (y_nxt == 16'h0000);
        end
        OP_ACC_B_PLUS_INDEX_ONE: x_nxt = x_r + {8'h00, b_r};
        OP_ACC_B_PLUS_INDEX_TWO: y_nxt = y_r + {8'h00, b_r};
        OP_EXCHANGE_D_INDEX_ONE: begin
          x_nxt = {a_r, b_r};
          {a_nxt, b_nxt} = x_r;
        end
        OP_SHIFT_LEFT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
          if (ins.op == OP_ROTATE_RIGHT) begin
            {a_nxt, flags_nxt[FB_C]} = {flags_r[FB_C], a_r};
          end else begin
            {flags_nxt[FB_C], a_nxt} = {a_r, (ins.op == OP_ROTATE_LEFT) & flags_r[FB_C]};
          end
          flags_nxt[FB_N] = a_nxt[7];
          flags_nxt[FB_Z] = (a_nxt == 8'h00);
          flags_nxt[FB_V] = a_nxt[7] ^ flags_nxt[FB_C];
        end
        OP_MULTIPLY: begin
          {a_nxt, b_nxt} = prod;
          flags_nxt[FB_C] = prod[7];
        end
        OP_BRANCH: begin
          // condition on N Z V C
          if (cond_true(ins.cond, flags_r)) begin
            pc_nxt = br_to;
          end
        end
        OP_STOP: begin
          halted_nxt = ~flags_r[FB_S];
        end
        OP_CLEAR_I: flags_nxt[FB_I] = 1'b0;
        OP_SET_I:   flags_nxt[FB_I] = 1'b1;
        OP_ACC_TO_FLAGS: begin
          // X can be cleared, never set, by software
          flags_nxt = {a_r[7], a_r[6] & flags_r[FB_X], a_r[5:0]};
        end
        OP_RETURN_FROM_INTERRUPT: begin
          pc_nxt    = pc_r;
          state_nxt = ST_PULL;
          cnt_nxt   = 4'h0;
        end
        default: ;
      endcase
    end else if (wr_hit) begin
      case (reg_addr_in)
        REG_PC:  pc_nxt = reg_wdata_in[15:0];
        REG_SP:  sp_nxt = reg_wdata_in[15:0];
        REG_ACC: {a_nxt, b_nxt} = reg_wdata_in[15:0];
        REG_IDX: {y_nxt, x_nxt} = reg_wdata_in;
        default: ;
      endcase
    end
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt   = ST_PUSH;
          cnt_nxt     = 4'h0;
          pin_sel_nxt = want_pin;
          halted_nxt  = 1'b0;
        end
      end
      ST_PUSH: begin
        // pointer stays on next free byte
        sp_nxt  = sp_dn;
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == PUSH_LAST) begin
          state_nxt = ST_VEC;
        end
      end
      ST_VEC: begin
        flags_nxt[FB_I] = 1'b1;
        if (pin_sel_r) begin
          flags_nxt[FB_X] = 1'b1;
          pin_pend_nxt    = nonmaskable_pin_request_in;
          pc_nxt          = VEC_PIN;
        end else begin
          irq_pend_nxt = irq_req_in;
          pc_nxt       = VEC_IRQ;
        end
        state_nxt = ST_IDLE;
      end
      ST_PULL: begin
        if (cnt_r != PULL_LAST) begin
          sp_nxt = sp_up;
        end
        if (cnt_r != 4'h0) begin
          case (pidx)
            4'h0:    pc_nxt[7:0]  = stk_rdata;
            4'h1:    pc_nxt[15:8] = stk_rdata;
            4'h2:    y_nxt[7:0]   = stk_rdata;
            4'h3:    y_nxt[15:8]  = stk_rdata;
            4'h4:    x_nxt[7:0]   = stk_rdata;
            4'h5:    x_nxt[15:8]  = stk_rdata;
            4'h6:    a_nxt        = stk_rdata;
            4'h7:    b_nxt        = stk_rdata;
            default: flags_nxt    = {stk_rdata[7], stk_rdata[6] & flags_r[FB_X], stk_rdata[5:0]};
          endcase
        end
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == PULL_LAST) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  wire [31:0] rd_val =
    (reg_addr_in == REG_FLAGS) ? {24'h00_0000, flags_r} :
    (reg_addr_in == REG_PC)    ? {16'h0000, pc_r} :
    (reg_addr_in == REG_ACC)   ? {16'h0000, a_r, b_r} :
    (reg_addr_in == REG_IDX)   ? {y_r, x_r} :
    (reg_addr_in == REG_SP)    ? {16'h0000, sp_r} :
    (reg_addr_in == REG_STAT)  ? {24'h00_0000, 2'b00, halted_r, busy_r, pin_pend_r, irq_pend_r, state_r} :
                                 32'h0000_0000;

  // ----------------------------------------
  // flops
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      flags_r <= FLAGS_RST;
      pc_r    <= PC_RST;
      sp_r    <= SP_RST;
      {x_r, y_r, a_r, b_r} <= 48'h0000_0000_0000;
      {irq_pend_r, pin_pend_r, pin_sel_r, halted_r, busy_r} <= 5'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      flags_r <= flags_nxt;
      pc_r    <= pc_nxt;
      sp_r    <= sp_nxt;
      {x_r, y_r, a_r, b_r} <= {x_nxt, y_nxt, a_nxt, b_nxt};
      {irq_pend_r, pin_pend_r, pin_sel_r, halted_r} <= {irq_pend_nxt, pin_pend_nxt, pin_sel_nxt, halted_nxt};
      busy_r  <= (state_nxt != ST_IDLE);
      rdata_r <= reg_rd_in ? rd_val : 32'h0000_0000;
    end
  end

  assign reg_rdata_out       = rdata_r;
  assign flag_register_out   = flags_r;
  assign program_counter_out = pc_r;
  assign busy_out            = busy_r;
  assign halted_out          = halted_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_reset_masks: assert property ($past(sys_rst_in) |-> flags_r[FB_X] && flags_r[FB_I])
    else $error("masks not set after reset");
  a_pc_step: assert property (ins_go && ins.op == OP_NO_OPERATION |=> pc_r == $past(pc_r) + 16'h0001)
    else $error("pc did not step by one");
  a_half_carry: assert property (ins_go && ins.op == OP_ADD |=>
    flags_r[FB_H] == (({1'b0, $past(a_r[3:0])} + {1'b0, $past(reg_wdata_in[11:8])}) > 5'h0F))
    else $error("half carry wrong");
  a_index_zero: assert property (ins_go && ins.op == OP_INCREMENT_INDEX_ONE |=>
    flags_r[7:3] == $past(flags_r[7:3]) && flags_r[1:0] == $past(flags_r[1:0]) && flags_r[FB_Z] == (x_r == 16'h0000))
    else $error("index step touched other flags");
  a_quiet_ops: assert property (ins_go && ins.op inside {OP_ACC_B_PLUS_INDEX_ONE, OP_ACC_B_PLUS_INDEX_TWO,
    OP_EXCHANGE_D_INDEX_ONE} |=> $stable(flags_r))
    else $error("flags changed by quiet op");
  a_entry_len: assert property (take |-> ##1 (state_r == ST_PUSH)[*8] ##2 state_r == ST_VEC)
    else $error("entry push length wrong");
  a_vec_masks: assert property (state_r == ST_VEC |=> flags_r[FB_I] && (flags_r[FB_X] || !$past(pin_sel_r)))
    else $error("masks not set at vector");
  a_irq_held: assert property (flags_r[FB_I] && !want_pin |-> !take)
    else $error("masked request taken");
  a_sp_push: assert property (state_r == ST_PUSH |=> sp_r == $past(sp_r) - 16'h0001)
    else $error("stack pointer not decremented");
  a_stop_skip: assert property (ins_go && ins.op == OP_STOP && flags_r[FB_S] |=> !halted_r)
    else $error("disabled stop halted");
  a_rti_len: assert property (ins_go && ins.op == OP_RETURN_FROM_INTERRUPT |->
    ##1 (state_r == ST_PULL)[*8] ##2 state_r == ST_PULL ##1 state_r == ST_IDLE)
    else $error("return pull length wrong");

  c_pin_entry: cover property (take && want_pin);
  c_irq_entry: cover property (take && !want_pin);
  c_return:    cover property (ins_go && ins.op == OP_RETURN_FROM_INTERRUPT);
  c_halt:      cover property (ins_go && ins.op == OP_STOP && !flags_r[FB_S]);
endmodule
`default_nettype wire

// *** logic/cfi_pkg.sv ***
`default_nettype none
package cfi_pkg;
  // ----------------------------------------
  // register map, word aligned
  // ----------------------------------------
  localparam logic [7:0]  REG_INSTR = 8'h00;
  localparam logic [7:0]  REG_FLAGS = 8'h04;
  localparam logic [7:0]  REG_PC    = 8'h08;
  localparam logic [7:0]  REG_ACC   = 8'h0C;
  localparam logic [7:0]  REG_IDX   = 8'h10;
  localparam logic [7:0]  REG_SP    = 8'h14;
  localparam logic [7:0]  REG_STAT  = 8'h18;
  // ----------------------------------------
  // flag register bit positions
  // ----------------------------------------
  localparam int unsigned FB_C = 0;
  localparam int unsigned FB_V = 1;
  localparam int unsigned FB_Z = 2;
  localparam int unsigned FB_N = 3;
  localparam int unsigned FB_I = 4;
  localparam int unsigned FB_H = 5;
  localparam int unsigned FB_X = 6;
  localparam int unsigned FB_S = 7;
  // ----------------------------------------
  // reset values, vectors, sequence lengths
  // ----------------------------------------
  localparam logic [7:0]  FLAGS_RST  = 8'hD0;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [15:0] SP_RST     = 16'h00FF;
  localparam logic [15:0] VEC_IRQ    = 16'hFFF2;
  localparam logic [15:0] VEC_PIN    = 16'hFFF4;
  localparam logic [3:0]  PUSH_LAST  = 4'h8;
  localparam logic [3:0]  PULL_LAST  = 4'h9;
  localparam int          STK_AW     = 8;

  typedef enum logic [4:0] {
    OP_NO_OPERATION, OP_ADD_B_INTO_A, OP_ADD, OP_ADC, OP_SUB, OP_CMP,
    OP_DECIMAL_ADJUST_ACC, OP_LOAD_ACC_ONE, OP_STORE_ACC_ONE, OP_LOAD_ACC_TWO,
    OP_INCREMENT_INDEX_ONE, OP_DECREMENT_INDEX_ONE, OP_INCREMENT_INDEX_TWO,
    OP_DECREMENT_INDEX_TWO, OP_ACC_B_PLUS_INDEX_ONE, OP_ACC_B_PLUS_INDEX_TWO,
    OP_EXCHANGE_D_INDEX_ONE, OP_SHIFT_LEFT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
    OP_MULTIPLY, OP_BRANCH, OP_STOP, OP_CLEAR_I, OP_SET_I, OP_ACC_TO_FLAGS,
    OP_RETURN_FROM_INTERRUPT
  } cfi_op_t;

  typedef enum logic [3:0] {
    BR_MI, BR_PL, BR_EQ, BR_NE, BR_VS, BR_VC, BR_CS, BR_CC,
    BR_LT, BR_GE, BR_LE, BR_GT, BR_HI, BR_LS, BR_ALWAYS, BR_NEVER
  } cfi_cond_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_VEC  = 2'b11,
    ST_PULL = 2'b10
  } cfi_state_t;

  typedef struct packed {
    cfi_cond_t  cond;
    logic [7:0] imm;
    logic [2:0] pad;
    cfi_op_t    op;
  } cfi_instr_t;

  typedef struct packed {
    logic              we;
    logic [STK_AW-1:0] addr;
    logic [7:0]        data;
  } cfi_stk_req_t;
endpackage
`default_nettype wire

// *** logic/cfi_stack_mem.sv ***
`default_nettype none
module cfi_stack_mem
  import cfi_pkg::*;
(
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  input  wire cfi_stk_req_t req_in,
  output logic [7:0]        rdata_out
);
  logic [7:0] mem [1<<STK_AW];
  logic [7:0] rdata_r;

  always_ff @(posedge core_clk_in) begin
    if (req_in.we) begin
      mem[req_in.addr] <= req_in.data;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= mem[req_in.addr];
    end
  end

  assign rdata_out = rdata_r;
endmodule
`default_nettype wire

// *** tb/cfi_irq_src.sv ***
`default_nettype none
module cfi_irq_src (
  input  wire logic core_clk_in,
  output var  logic irq_req_out,
  output var  logic pin_req_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    irq_req_out = 1'b0;
    pin_req_out = 1'b0;
  end

  // one-cycle pulses: the core must remember them as pending itself
  task automatic pulse(input logic irq, input logic pin);
    @(posedge core_clk_in);
    irq_req_out <= irq;
    pin_req_out <= pin;
    @(posedge core_clk_in);
    irq_req_out <= 1'b0;
    pin_req_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_cpu_flags_and_interrupt_entry.sv ***
`default_nettype none
module tb_cpu_flags_and_interrupt_entry
  import cfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        irq;
  logic        pin;
  logic        busy;
  logic [31:0] rdata;
  logic [7:0]  flg_o;
  logic [15:0] pc_o;
  logic        halted_o;
  logic [31:0] exp_q[$];
  string       nam_q[$];
  int          n_errors   = 0;
  int          n_compared = 0;
  logic [31:0] seed = 32'h0001_4A5E;
  logic [31:0] r;
  logic [15:0] pc;
  logic [8:0]  s;
  logic [7:0]  flg;
  logic [7:0]  a;
  logic [7:0]  b;

  always #2.5 clk = ~clk;

  cfi_irq_src cfi_irq_src_inst (
    .core_clk_in (clk),
    .irq_req_out (irq),
    .pin_req_out (pin)
  );

  cfi_core cfi_core_inst (
    .core_clk_in                (clk),
    .sys_rst_in                 (rst),
    .reg_addr_in                (addr),
    .reg_wdata_in               (wdata),
    .reg_wr_in                  (wr),
    .reg_rd_in                  (rd),
    .irq_req_in                 (irq),
    .nonmaskable_pin_request_in (pin),
    .reg_rdata_out              (rdata),
    .flag_register_out          (flg_o),
    .program_counter_out        (pc_o),
    .busy_out                   (busy),
    .halted_out                 (halted_o)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] ins(cfi_op_t o, logic [7:0] i);
    return {16'h0000, i, 3'b000, o};
  endfunction

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wreg(logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= ad;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic exec(cfi_op_t o, logic [7:0] i);
    wreg(REG_INSTR, ins(o, i));
    pc++;
  endtask

  task automatic rreg(string n, logic [7:0] ad, logic [31:0] e);
    exp_q.push_back(e);
    nam_q.push_back(n);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // fixed window, long enough for entry or return to finish
  task automatic serve(logic [15:0] vec);
    int n;
    n = 0;
    // first look is just after the edge that may already start a return
    for (int k = 0; k < 30; k++) begin
      #1;
      n += (busy === 1'b1);
      @(posedge clk);
    end
    #1;
    chk("busy cycles", 32'h0000_000A, n);
    chk("pc out", {16'h0000, vec}, {16'h0000, pc_o});
    rreg("pc", REG_PC, {16'h0000, vec});
  endtask

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // read data monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (rd === 1'b1) begin
      #1;
      if (exp_q.size() == 0) begin
        chk("read queue", 32'h0000_0000, 32'h0000_0001);
      end else begin
        chk(nam_q.pop_front(), exp_q.pop_front(), rdata);
      end
    end
  end

  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    test_done();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    pc  = 16'h0000;
    flg = FLAGS_RST;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rreg("flags", REG_FLAGS, {24'h00_0000, flg});
    rreg("pc", REG_PC, 32'h0000_0000);
    rreg("sp", REG_SP, {16'h0000, SP_RST});
    rreg("unmapped", 8'h1C, 32'h0000_0000);
    // first pass forces zero, carry and overflow at once
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      a = (i == 0) ? 8'h80 : r[7:0];
      b = (i == 0) ? 8'h80 : r[15:8];
      wreg(REG_ACC, {16'h0000, a, 8'h00});
      exec(OP_ADD, b);
      s = {1'b0, a} + {1'b0, b};
      flg[FB_H] = a[4] ^ b[4] ^ s[4];
      flg[FB_N] = s[7];
      flg[FB_Z] = (s[7:0] == 8'h00);
      flg[FB_V] = (a[7] == b[7]) && (s[7] != a[7]);
      flg[FB_C] = s[8];
      rreg("acc", REG_ACC, {16'h0000, s[7:0], 8'h00});
      rreg("flags", REG_FLAGS, {24'h00_0000, flg});
      chk("flags out", {24'h00_0000, flg}, {24'h00_0000, flg_o});
    end
    wreg(REG_IDX, 32'h1234_FFFF);
    exec(OP_INCREMENT_INDEX_ONE, 8'h00);
    flg[FB_Z] = 1'b1;
    rreg("index", REG_IDX, 32'h1234_0000);
    rreg("flags", REG_FLAGS, {24'h00_0000, flg});
    // zero is set here, so the equal branch is taken
    wreg(REG_INSTR, ins(OP_BRANCH, 8'h10) | {12'h000, BR_EQ, 16'h0000});
    pc += 16'h0011;
    exec(OP_STOP, 8'h00);
    rreg("status", REG_STAT, 32'h0000_0000);
    rreg("pc", REG_PC, {16'h0000, pc});
    cfi_irq_src_inst.pulse(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    rreg("status", REG_STAT, 32'h0000_000C);
    wreg(REG_ACC, 32'h0000_C000);
    exec(OP_ACC_TO_FLAGS, 8'h00);
    serve(VEC_IRQ);
    rreg("sp", REG_SP, {16'h0000, SP_RST - 16'h0009});
    rreg("flags", REG_FLAGS, 32'h0000_00D0);
    wreg(REG_INSTR, ins(OP_RETURN_FROM_INTERRUPT, 8'h00));
    serve(pc);
    rreg("flags", REG_FLAGS, 32'h0000_00C0);
    rreg("sp", REG_SP, {16'h0000, SP_RST});
    rreg("status", REG_STAT, 32'h0000_0008);
    wreg(REG_ACC, 32'h0000_8000);
    exec(OP_ACC_TO_FLAGS, 8'h00);
    serve(VEC_PIN);
    rreg("flags", REG_FLAGS, 32'h0000_00D0);
    wreg(REG_INSTR, ins(OP_RETURN_FROM_INTERRUPT, 8'h00));
    serve(pc);
    rreg("flags", REG_FLAGS, 32'h0000_0080);
    exec(OP_NO_OPERATION, 8'h00);
    wreg(REG_ACC, 32'h0000_0005);
    exec(OP_ACC_B_PLUS_INDEX_ONE, 8'h00);
    rreg("index", REG_IDX, 32'h1234_0005);
    rreg("flags", REG_FLAGS, 32'h0000_0080);
    rreg("pc", REG_PC, {16'h0000, pc});
    // stop with the disable bit clear halts until an interrupt is taken
    exec(OP_ACC_TO_FLAGS, 8'h00);
    exec(OP_STOP, 8'h00);
    rreg("status", REG_STAT, 32'h0000_0020);
    chk("halted out", 32'h0000_0001, {31'h0000_0000, halted_o});
    wreg(REG_PC, 32'h0000_1234);
    cfi_irq_src_inst.pulse(1'b1, 1'b0);
    serve(VEC_IRQ);
    chk("halted out", 32'h0000_0000, {31'h0000_0000, halted_o});
    rreg("flags", REG_FLAGS, 32'h0000_0010);
    wreg(REG_INSTR, ins(OP_RETURN_FROM_INTERRUPT, 8'h00));
    serve(pc);
    rreg("flags", REG_FLAGS, 32'h0000_0000);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
